// ---- hdl/rtcal_cal_if.sv ----
`timescale 1ns/1ps
interface rtcal_cal_if;
  import rtcal_pkg::*;
  logic         load;
  rtcal_value_t load_value;
  logic         run;
  logic         twelve_hour;
  logic         tick;
  rtcal_value_t value;

  modport ctl (output load, output load_value, output run,
               output twelve_hour, input tick, input value);
  modport cal (input load, input load_value, input run,
               input twelve_hour, input tick, output value);
endinterface : rtcal_cal_if

// ---- hdl/rtcal_calendar.sv ----
`timescale 1ns/1ps
`include "rtcal_defines.svh"
module rtcal_calendar (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  rtcal_cal_if.cal  cal
);
  import rtcal_pkg::*;

  rtcal_value_t val;
  rtcal_value_t next_val;

  // month length, leap when the two low year bits are zero
  function automatic logic [4:0] month_days(input logic [3:0] m,
                                            input logic [5:0] y);
    case (m)
      `RTCAL_MONTH_FEB: month_days = (y[1:0] == 2'h0) ? `RTCAL_DAYS_29
                                                       : `RTCAL_DAYS_28;
      `RTCAL_MONTH_APR, `RTCAL_MONTH_JUN,
      `RTCAL_MONTH_SEP, `RTCAL_MONTH_NOV: month_days = `RTCAL_DAYS_30;
      default: month_days = `RTCAL_DAYS_31;
    endcase
  endfunction : month_days

  // software load wins over a tick in the same cycle
  always_comb begin
    logic day_carry;
    day_carry = 1'b0;
    next_val  = val;
    if (cal.load) begin
      next_val = cal.load_value;
    end else if (cal.tick && cal.run) begin
      if (val.second != `RTCAL_SEC_MAX) begin
        next_val.second = val.second + 6'h01;
      end else begin
        next_val.second = '0;
        if (val.minute != `RTCAL_MIN_MAX) begin
          next_val.minute = val.minute + 6'h01;
        end else begin
          next_val.minute = '0;
          if (cal.twelve_hour) begin
            // 12h: 11 -> 12 flips am/pm, 12 -> 1
            if (val.hour[3:0] == `RTCAL_HOUR12_MAX) begin
              next_val.hour[3:0] = `RTCAL_HOUR12_FIRST;
            end else if (val.hour[3:0] == `RTCAL_HOUR12_LAST) begin
              next_val.hour[3:0] = `RTCAL_HOUR12_MAX;
              next_val.hour[4]   = ~val.hour[4];
              day_carry          = val.hour[4];
            end else begin
              next_val.hour[3:0] = val.hour[3:0] + 4'h1;
            end
          end else if (val.hour >= `RTCAL_HOUR24_MAX) begin
            next_val.hour = '0;
            day_carry     = 1'b1;
          end else begin
            next_val.hour = val.hour + 5'h01;
          end
        end
      end
      if (day_carry) begin
        if (val.day < month_days(val.month, val.year)) begin
          next_val.day = val.day + 5'h01;
        end else begin
          next_val.day = `RTCAL_DAY_FIRST;
          if (val.month < `RTCAL_MONTH_MAX) begin
            next_val.month = val.month + 4'h1;
          end else begin
            next_val.month = `RTCAL_MONTH_FIRST;
            next_val.year  = val.year + 6'h01; // wraps in six bits
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      val <= rtcal_value_t'(`RTCAL_VALUE_RESET);
    end else begin
      val <= next_val;
    end
  end

  assign cal.value = val;
endmodule : rtcal_calendar

// ---- hdl/rtcal_defines.svh ----
`ifndef RTCAL_DEFINES_SVH
`define RTCAL_DEFINES_SVH

// register byte offsets
`define RTCAL_OFS_CONTROL_REGISTER_A        8'h00
`define RTCAL_OFS_STATUS       8'h04
`define RTCAL_OFS_VALUE        8'h18

// control_register_a fields
`define RTCAL_CTRL_ENABLE_BIT  1
`define RTCAL_CTRL_MODE_LSB    2
`define RTCAL_CTRL_MODE_MSB    3
`define RTCAL_CTRL_HFMT_BIT    6
`define RTCAL_CTRL_RW_MASK     32'h0000004E
`define RTCAL_MODE_CALENDAR    2'h2

// status register fields
`define RTCAL_STAT_BUSY_BIT    0
`define RTCAL_STAT_PROT_BIT    1

// reset values
`define RTCAL_CTRL_RESET       32'h00000000
`define RTCAL_VALUE_RESET      32'h00000000

// field limits
`define RTCAL_SEC_MAX          6'h3B
`define RTCAL_MIN_MAX          6'h3B
`define RTCAL_HOUR24_MAX       5'h17
`define RTCAL_HOUR12_MAX       4'hC
`define RTCAL_HOUR12_LAST      4'hB
`define RTCAL_HOUR12_FIRST     4'h1
`define RTCAL_MONTH_FEB        4'h2
`define RTCAL_MONTH_APR        4'h4
`define RTCAL_MONTH_JUN        4'h6
`define RTCAL_MONTH_SEP        4'h9
`define RTCAL_MONTH_NOV        4'hB
`define RTCAL_MONTH_MAX        4'hC
`define RTCAL_MONTH_FIRST      4'h1
`define RTCAL_DAY_FIRST        5'h01
`define RTCAL_DAYS_28          5'h1C
`define RTCAL_DAYS_29          5'h1D
`define RTCAL_DAYS_30          5'h1E
`define RTCAL_DAYS_31          5'h1F

// timing: one calendar second at the reference clock
`define RTCAL_SECOND_MS        1000
`define RTCAL_CLK_PERIOD_NS    100
`define RTCAL_SECOND_CYCLES    ((`RTCAL_SECOND_MS * 1000000) / `RTCAL_CLK_PERIOD_NS)

// AXI4-Lite responses
`define RTCAL_RESP_OKAY        2'h0
`define RTCAL_RESP_SLVERR      2'h2

`endif

// ---- hdl/rtcal_pkg.sv ----
package rtcal_pkg;

  // packed calendar word, msb first
  typedef struct packed {
    logic [5:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } rtcal_value_t;

  typedef logic [1:0] rtcal_mode_t;

endpackage : rtcal_pkg

// ---- hdl/rtcal_tick.sv ----
`timescale 1ns/1ps
`include "rtcal_defines.svh"
module rtcal_tick #(
  parameter int unsigned CYCLES = `RTCAL_SECOND_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  input  wire logic restart_i,
  output logic      tick_o
);
  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  // restart aligns a fresh second to every software load
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (restart_i || !run_i) begin
      next_cnt = '0;
    end else if (cnt == LAST) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      tick_o <= next_tick;
    end
  end
endmodule : rtcal_tick

// ---- hdl/rtcal_top.sv ----
// Summary of operation
// - The calendar fields count only while the mode field selects 2.
// - Value writes pass a sync stage, reads take the live or pending word; protected writes are refused.
// - Year is a six-bit offset at bits 31:26 from a software reference.
// - A year whose two low bits are zero is leap and gives February 29 days.
// - Month sits at bits 25:22 and runs from 1 to 12.
// - Day sits at bits 21:17 and runs from 1 to the month length.
// - With hour format clear the hour at bits 16:12 runs 0 to 23.
// - With hour format set hour bits 3:0 run 1 to 12, bit 4 is pm.
// - Minute sits at bits 11:6 and runs 0 to 59.
`timescale 1ns/1ps
`include "rtcal_defines.svh"
module rtcal_top #(
  parameter int unsigned SECOND_CYCLES = `RTCAL_SECOND_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        write_protect_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);
  import rtcal_pkg::*;

  // reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // protection level arrives from another unit, synchronise it
  logic prot_meta;
  logic prot;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prot_meta <= 1'b0;
      prot      <= 1'b0;
    end else begin
      prot_meta <= write_protect_i;
      prot      <= prot_meta;
    end
  end

  rtcal_cal_if cal_bus ();

  rtcal_calendar u_calendar (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n),
    .cal       (cal_bus.cal)
  );

  rtcal_tick #(
    .CYCLES (SECOND_CYCLES)
  ) u_tick (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n),
    .run_i     (cal_bus.run),
    .restart_i (cal_bus.load),
    .tick_o    (cal_bus.tick)
  );

  // register state
  logic [31:0]  ctrl;
  logic [31:0]  next_ctrl;
  logic         load_pend;
  logic         next_load_pend;
  rtcal_value_t load_word;
  rtcal_value_t next_load_word;

  // write channel state
  logic         aw_got;
  logic         next_aw_got;
  logic [7:0]   aw_addr;
  logic [7:0]   next_aw_addr;
  logic         w_got;
  logic         next_w_got;
  logic [31:0]  w_data;
  logic [31:0]  next_w_data;
  logic [3:0]   w_strb;
  logic [3:0]   next_w_strb;
  logic         next_awready;
  logic         next_wready;
  logic         next_bvalid;
  logic [1:0]   next_bresp;

  // read channel state
  logic         next_arready;
  logic         next_rvalid;
  logic [31:0]  next_rdata;
  logic [1:0]   next_rresp;

  rtcal_mode_t  mode;
  logic         calendar_mode;

  assign mode          = ctrl[`RTCAL_CTRL_MODE_MSB:`RTCAL_CTRL_MODE_LSB];
  assign calendar_mode = (mode == `RTCAL_MODE_CALENDAR);

  // calendar control: count only when enabled in calendar mode
  assign cal_bus.run         = calendar_mode && ctrl[`RTCAL_CTRL_ENABLE_BIT];
  assign cal_bus.twelve_hour = ctrl[`RTCAL_CTRL_HFMT_BIT];
  assign cal_bus.load        = load_pend;
  assign cal_bus.load_value  = load_word;

  // byte-lane merge of a write onto an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // write path: address and data taken in either order
  always_comb begin
    logic do_write;
    do_write       = 1'b0;
    next_aw_got    = aw_got;
    next_aw_addr   = aw_addr;
    next_w_got     = w_got;
    next_w_data    = w_data;
    next_w_strb    = w_strb;
    next_bvalid    = s_axi_bvalid_o;
    next_bresp     = s_axi_bresp_o;
    next_ctrl      = ctrl;
    next_load_pend = 1'b0; // load lasts a single cycle
    next_load_word = load_word;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_got  = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_got  = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (aw_got && w_got && !s_axi_bvalid_o) begin
      do_write    = 1'b1;
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = `RTCAL_RESP_OKAY;
    end
    if (do_write) begin
      if (prot) begin
        // protected block: nothing stored, error answered
        next_bresp = `RTCAL_RESP_SLVERR;
      end else begin
        case (aw_addr)
          `RTCAL_OFS_CONTROL_REGISTER_A: begin
            next_ctrl = merge(ctrl, w_data, w_strb)
                        & `RTCAL_CTRL_RW_MASK;
          end
          `RTCAL_OFS_VALUE: begin
            // staged one cycle, then handed to the counter
            next_load_word = rtcal_value_t'(merge(cal_bus.value,
                                                  w_data, w_strb));
            next_load_pend = 1'b1;
          end
          `RTCAL_OFS_STATUS: begin
            next_bresp = `RTCAL_RESP_OKAY; // read-only, write ignored
          end
          default: begin
            next_bresp = `RTCAL_RESP_SLVERR;
          end
        endcase
      end
    end
    // ready only while the slot is free and no answer waits
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;
  end

  // read path: value word is sampled once, answer held until taken
  always_comb begin
    next_rvalid = s_axi_rvalid_o;
    next_rdata  = s_axi_rdata_o;
    next_rresp  = s_axi_rresp_o;
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rresp  = `RTCAL_RESP_OKAY;
      case (s_axi_araddr_i)
        `RTCAL_OFS_CONTROL_REGISTER_A: begin
          next_rdata = ctrl;
        end
        `RTCAL_OFS_STATUS: begin
          next_rdata = '0;
          next_rdata[`RTCAL_STAT_BUSY_BIT] = load_pend;
          next_rdata[`RTCAL_STAT_PROT_BIT] = prot;
        end
        `RTCAL_OFS_VALUE: begin
          // pending load shown so a read never sees the stale word
          next_rdata = load_pend ? load_word
                                 : cal_bus.value;
        end
        default: begin
          next_rdata = '0;
          next_rresp = `RTCAL_RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  // field layout, leap rule and carries live in the packed word
  // and in the calendar counter

  // all register state, zero from reset
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl            <= `RTCAL_CTRL_RESET;
      load_pend       <= 1'b0;
      load_word       <= rtcal_value_t'(`RTCAL_VALUE_RESET);
      aw_got          <= 1'b0;
      aw_addr         <= '0;
      w_got           <= 1'b0;
      w_data          <= '0;
      w_strb          <= '0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `RTCAL_RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= `RTCAL_RESP_OKAY;
    end else begin
      ctrl            <= next_ctrl;
      load_pend       <= next_load_pend;
      load_word       <= next_load_word;
      aw_got          <= next_aw_got;
      aw_addr         <= next_aw_addr;
      w_got           <= next_w_got;
      w_data          <= next_w_data;
      w_strb          <= next_w_strb;
      s_axi_awready_o <= next_awready;
      s_axi_wready_o  <= next_wready;
      s_axi_bvalid_o  <= next_bvalid;
      s_axi_bresp_o   <= next_bresp;
      s_axi_arready_o <= next_arready;
      s_axi_rvalid_o  <= next_rvalid;
      s_axi_rdata_o   <= next_rdata;
      s_axi_rresp_o   <= next_rresp;
    end
  end
endmodule : rtcal_top

// ---- tb/rtcal_props.sv ----
`timescale 1ns/1ps
module rtcal_props #(
  parameter int unsigned SECOND_CYCLES = 4
) (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic        write_protect_i,
  input wire logic [7:0]  s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0]  s_axi_wstrb_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // handshakes seen at an edge
  logic aw_t;
  logic w_t;
  logic ar_t;
  logic ar_unmapped;
  assign aw_t = s_axi_awvalid_i && s_axi_awready_o;
  assign w_t  = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_t = s_axi_arvalid_i && s_axi_arready_o;
  assign ar_unmapped = !(s_axi_araddr_i inside {8'h00, 8'h04, 8'h18});

  a_read_answer: assert property (ar_t |=> s_axi_rvalid_o)
    else $error("read answer not one cycle after address");
  a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read answer dropped before rready");
  a_arready_back: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
    !s_axi_rvalid_o && s_axi_arready_o)
    else $error("read channel not free after handshake");
  a_write_answer: assert property (aw_t && w_t |-> ##2 s_axi_bvalid_o)
    else $error("write answer not two cycles after take");
  a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped before bready");
  a_busy_no_ready: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o)
    else $error("write slots open while answer pending");
  a_protect_refused: assert property (write_protect_i [*4] ##0
    (aw_t && w_t) |-> ##2 (s_axi_bvalid_o && s_axi_bresp_o == 2'h2))
    else $error("protected write not refused");
  a_value_write_ok: assert property (!write_protect_i [*4] ##0
    (aw_t && w_t && s_axi_awaddr_i == 8'h18) |-> ##2 s_axi_bresp_o == 2'h0)
    else $error("open value write not accepted");
  a_unmapped_read: assert property (ar_t && ar_unmapped |=>
    s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h00000000)
    else $error("unmapped read not refused");

  // main traffic reached
  c_value_read: cover property (ar_t && s_axi_araddr_i == 8'h18);
  c_refused: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
  c_joint_take: cover property (aw_t && w_t);
endmodule : rtcal_props

// ---- tb/rtcal_top_test.sv ----
`timescale 1ns/1ps
bind rtcal_top rtcal_props #(.SECOND_CYCLES(SECOND_CYCLES)) rtcal_props_i (.*);
module rtcal_top_test;
  import rtcal_pkg::*;
  localparam int unsigned SECOND_CYCLES = 40;
  // in range word and the same word one second on
  localparam logic [31:0] VAL_A = {6'h01, 4'h1, 5'h0F, 5'h0A, 6'h14, 6'h1E};
  localparam logic [31:0] VAL_B = {6'h01, 4'h1, 5'h0F, 5'h0A, 6'h14, 6'h1F};
  logic        ref_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        write_protect_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00;
  logic        s_axi_awvalid_i = 1'b0;
  logic        s_axi_awready_o;
  logic [31:0] s_axi_wdata_i = 32'h00000000;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic        s_axi_wvalid_i = 1'b0;
  logic        s_axi_wready_o;
  logic [1:0]  s_axi_bresp_o;
  logic        s_axi_bvalid_o;
  logic        s_axi_bready_i = 1'b0;
  logic [7:0]  s_axi_araddr_i = 8'h00;
  logic        s_axi_arvalid_i = 1'b0;
  logic        s_axi_arready_o;
  logic [31:0] s_axi_rdata_o;
  logic [1:0]  s_axi_rresp_o;
  logic        s_axi_rvalid_o;
  logic        s_axi_rready_i = 1'b0;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic [1:0]  rsp;

  rtcal_top #(.SECOND_CYCLES(SECOND_CYCLES)) rtcal_top_i (.*);

  // 10 MHz reference
  always #50 ref_clk_i = ~ref_clk_i;

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // ceiling well above the ~1100 cycles the run needs
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    logic aw;
    logic w;
    logic b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (b) begin
      @(posedge ref_clk_i);
      if (aw && s_axi_awready_o) begin
        aw = 1'b0;
        s_axi_awvalid_i <= 1'b0;
      end
      if (w && s_axi_wready_o) begin
        w = 1'b0;
        s_axi_wvalid_i <= 1'b0;
      end
      if (s_axi_bvalid_o) begin
        b = 1'b0;
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
      end
    end
  endtask : axi_write

  // rready held with arvalid so the answer is taken at once
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    logic ar;
    logic rv;
    ar = 1'b1;
    rv = 1'b1;
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    while (rv) begin
      @(posedge ref_clk_i);
      if (ar && s_axi_arready_o) begin
        ar = 1'b0;
        s_axi_arvalid_i <= 1'b0;
      end
      if (s_axi_rvalid_o) begin
        rv = 1'b0;
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
      end
    end
  endtask : axi_read

  // load hh:59:59, let one second pass, expect the carried word
  task automatic roll(input logic [5:0] y, input logic [3:0] mo,
                      input logic [4:0] d, input logic [4:0] h,
                      input logic f, input logic [5:0] ey,
                      input logic [3:0] emo, input logic [4:0] ed,
                      input logic [4:0] eh);
    logic [31:0] seen;
    logic [1:0]  r;
    // enable plus calendar mode, hour format bit on request
    axi_write(8'h00, f ? 32'h0000004A : 32'h0000000A, r);
    axi_write(8'h18, {y, mo, d, h, 12'hEFB}, r);
    // one tick lands between 40 and 80 cycles after the load
    repeat (60) @(posedge ref_clk_i);
    axi_read(8'h18, seen, r);
    chk(seen, {ey, emo, ed, eh, 12'h000});
  endtask : roll

  initial begin
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    axi_read(8'h18, rd, rsp);
    chk(rd, 32'h00000000);
    $display("test reset value done");
    // enabled but not calendar mode: word must not move
    axi_write(8'h00, 32'h00000002, rsp);
    axi_write(8'h18, VAL_A, rsp);
    chk({30'h0, rsp}, 32'h00000000);
    repeat (100) @(posedge ref_clk_i);
    axi_read(8'h18, rd, rsp);
    chk(rd, VAL_A);
    axi_write(8'h00, 32'h0000000A, rsp);
    repeat (60) @(posedge ref_clk_i);
    axi_read(8'h18, rd, rsp);
    chk(rd, VAL_B);
    $display("test mode gating done");
    roll(6'h05, 4'hC, 5'h1F, 5'h17, 1'b0, 6'h06, 4'h1, 5'h01, 5'h00);
    roll(6'h04, 4'h2, 5'h1C, 5'h17, 1'b0, 6'h04, 4'h2, 5'h1D, 5'h00);
    roll(6'h05, 4'h2, 5'h1C, 5'h17, 1'b0, 6'h05, 4'h3, 5'h01, 5'h00);
    roll(6'h08, 4'h2, 5'h1D, 5'h17, 1'b0, 6'h08, 4'h3, 5'h01, 5'h00);
    roll(6'h01, 4'h4, 5'h1E, 5'h17, 1'b0, 6'h01, 4'h5, 5'h01, 5'h00);
    roll(6'h01, 4'h1, 5'h1F, 5'h17, 1'b0, 6'h01, 4'h2, 5'h01, 5'h00);
    roll(6'h3F, 4'hC, 5'h1F, 5'h17, 1'b0, 6'h00, 4'h1, 5'h01, 5'h00);
    roll(6'h01, 4'h1, 5'h05, 5'h0A, 1'b0, 6'h01, 4'h1, 5'h05, 5'h0B);
    roll(6'h01, 4'h1, 5'h05, 5'h0B, 1'b1, 6'h01, 4'h1, 5'h05, 5'h1C);
    roll(6'h01, 4'h1, 5'h05, 5'h1B, 1'b1, 6'h01, 4'h1, 5'h06, 5'h0C);
    roll(6'h01, 4'h1, 5'h05, 5'h1C, 1'b1, 6'h01, 4'h1, 5'h05, 5'h11);
    roll(6'h01, 4'h1, 5'h05, 5'h0C, 1'b1, 6'h01, 4'h1, 5'h05, 5'h01);
    $display("test calendar carries done");
    // protected write must leave the held word alone
    axi_write(8'h00, 32'h00000002, rsp);
    axi_write(8'h18, VAL_A, rsp);
    write_protect_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    axi_read(8'h04, rd, rsp);
    chk(rd, 32'h00000002);
    axi_write(8'h18, 32'h00000000, rsp);
    chk({30'h0, rsp}, 32'h00000002);
    axi_read(8'h18, rd, rsp);
    chk(rd, VAL_A);
    write_protect_i <= 1'b0;
    $display("test protection done");
    // unmapped place on both channels
    axi_write(8'h20, 32'hFFFFFFFF, rsp);
    chk({30'h0, rsp}, 32'h00000002);
    axi_read(8'h20, rd, rsp);
    chk(rd, 32'h00000000);
    chk({30'h0, rsp}, 32'h00000002);
    $display("test unmapped done");
    finish_test();
  end
endmodule : rtcal_top_test
